// >>> hw/ioc_pkg.sv
// package: register map, field positions and reset values of the io cell
//
// What this block does
// - raw pad value skips capture registers and delays
// - optional fixed delay ahead of capture registers
// - bottom cells add five-bit runtime dynamic delay
// - single rate: one register captures pad input
// - double rate: rising and falling samples, two streams
// - rise output, fall-or-single-rate output
// - core gives first always, second in double rate
// - tristate register drives pad buffer enable control
// - local set/reset forces registers to initial state
// - right cells: shifted strobe clocks read, write
// - right cells: polarity select for capture edges
// - strobe inputs act on right edge only
// - cells bundle in groups of four
// - adjacent pair drives true and inverted output
// - top groups carry eight-to-one output serializer
// - serializer modes: seven, eight, two fours
// - serializer has three pipeline stages
package ioc_pkg;
  // byte addresses of the registers
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DELAY  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_GEAR   = 8'h0C;
  // control field positions
  localparam int CB_BYPASS = 0;
  localparam int CB_FIXDLY = 1;
  localparam int CB_DYNDLY = 2;
  localparam int CB_DDR    = 3;
  localparam int CB_STROBE = 4;
  localparam int CB_INIT   = 5;
  localparam int CB_COMP   = 6;
  localparam int CB_GEAR   = 7;
  localparam int CB_GMODE  = 8;
  localparam int CB_RUN    = 10;
  localparam int CTRL_W    = 11;
  // values after reset
  localparam logic [10:0] CTRL_RST  = 11'h000;
  localparam logic [4:0]  DELAY_RST = 5'h00;
  // delay line lengths in cycles
  localparam int FIX_DLY_CYC = 4;
  localparam int DYN_TAPS    = 32;
  // serializer modes
  typedef enum logic [1:0] {
    GM_SEVEN  = 2'h0,
    GM_WIDE   = 2'h1,
    GM_NARROW = 2'h2
  } ioc_gmode_t;
  // device edge on which the cell sits
  typedef enum logic [1:0] {
    EDGE_LEFT   = 2'h0,
    EDGE_TOP    = 2'h1,
    EDGE_BOTTOM = 2'h2,
    EDGE_RIGHT  = 2'h3
  } ioc_edge_t;
endpackage

// >>> hw/ioc_if.sv
// interface: parallel word stream from the buffer into the serializer
`timescale 1ns/1ns
interface ioc_if #(parameter int W = 8);
  logic         valid;  // word offered
  logic         ready;  // word taken
  logic [W-1:0] data;   // parallel word
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> hw/ioc_fifo2.sv
// module: two-entry buffer between register writes and serializer
`timescale 1ns/1ns
module ioc_fifo2 #(parameter int W = 8, parameter int DEPTH = 2) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // filling side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // draining side
  ioc_if.src                out
);
  logic [W-1:0] mem_q [DEPTH];  // storage entries
  logic [1:0]   cnt_q;          // entries held
  logic         wr_q;           // write index
  logic         rd_q;           // read index
  logic         push;
  logic         pop;

  assign in_ready  = (cnt_q != 2'(DEPTH));
  assign out.valid = (cnt_q != 2'h0);
  assign out.data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out.valid & out.ready;

  // occupancy count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 2'h0;
    else if (push & ~pop) cnt_q <= cnt_q + 2'h1;
    else if (pop & ~push) cnt_q <= cnt_q - 2'h1;
  end

  // write side storage and index
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
    end else if (push) begin
      mem_q[wr_q] <= in_data;
      wr_q        <= ~wr_q;
    end
  end

  // read index
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rd_q <= 1'b0;
    else if (pop) rd_q <= ~rd_q;
  end
endmodule

// >>> hw/ioc_gearbox.sv
// module: output serializer with slow, transfer and fast stages
`timescale 1ns/1ns
module ioc_gearbox #(parameter int W = 8) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // rate enables and control
  input  wire logic              slow_en,
  input  wire logic              fast_en,
  input  wire logic              enable,
  input  wire logic              lsr,
  input  wire ioc_pkg::ioc_gmode_t mode,
  // parallel words in
  ioc_if.snk                     in,
  // serial lanes out
  output logic                   ser_a,
  output logic                   ser_b,
  output logic                   busy
);
  typedef enum logic {GB_IDLE = 1'b0, GB_SHIFT = 1'b1} ioc_gb_st_t;
  ioc_gb_st_t   st_q;       // fast stage state
  logic [W-1:0] s1_q;       // slow stage word
  logic         s1_full_q;  // slow stage holds a word
  logic [W-1:0] sh_q;       // fast shift register
  logic [3:0]   cnt_q;      // bits left to shift
  logic [3:0]   len;        // bits per lane in this mode
  logic         load;

  // lane length per mode
  always_comb begin
    unique case (mode)
      ioc_pkg::GM_SEVEN:  len = 4'h7;
      ioc_pkg::GM_WIDE:   len = 4'h8;
      ioc_pkg::GM_NARROW: len = 4'h4;
      default:            len = 4'h8;
    endcase
  end

  assign in.ready = enable & slow_en & ~s1_full_q & ~lsr;
  assign load     = fast_en & s1_full_q & (st_q == GB_IDLE || cnt_q == 4'h1);
  assign busy     = (st_q == GB_SHIFT);

  // stage one: sample core word on the slow rate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q      <= '0;
      s1_full_q <= 1'b0;
    end else if (lsr) begin
      s1_full_q <= 1'b0;
    end else if (in.valid & in.ready) begin
      s1_q      <= in.data;
      s1_full_q <= 1'b1;
    end else if (load) begin
      s1_full_q <= 1'b0;
    end
  end

  // stage two and three: transfer then shift on fast rate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= GB_IDLE;
      sh_q  <= '0;
      cnt_q <= 4'h0;
    end else if (lsr) begin
      st_q  <= GB_IDLE;
      cnt_q <= 4'h0;
    end else if (load) begin
      st_q  <= GB_SHIFT;
      sh_q  <= s1_q;
      cnt_q <= len;
    end else if (fast_en && st_q == GB_SHIFT) begin
      // narrow mode shifts two independent nibbles
      if (mode == ioc_pkg::GM_NARROW)
        sh_q <= {1'b0, sh_q[7:5], 1'b0, sh_q[3:1]};
      else
        sh_q <= {1'b0, sh_q[7:1]};
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h1) st_q <= GB_IDLE;
    end
  end

  // serial lanes, lane b only in narrow mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_a <= 1'b0;
      ser_b <= 1'b0;
    end else begin
      ser_a <= busy & sh_q[0];
      ser_b <= busy & (mode == ioc_pkg::GM_NARROW) & sh_q[4];
    end
  end
endmodule

// >>> hw/ioc_top.sv
// module: one io logic cell with input, output, tristate paths and apb
`timescale 1ns/1ns
module ioc_top #(
  parameter ioc_pkg::ioc_edge_t EDGE     = ioc_pkg::EDGE_BOTTOM,
  parameter logic [1:0]         CELL_IDX = 2'h0,
  parameter int                 FIX_CYC  = ioc_pkg::FIX_DLY_CYC
) (
  // apb clock, reset and slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // pad side
  input  wire logic        pad_data_in,
  output logic             pad_data_out,
  output logic             pad_data_oe,
  output logic             pad_pair_out,
  output logic             pad_tristate_ctl,
  // clocks and strobe controls from pins
  input  wire logic        core_sys_clk,
  input  wire logic        edge_fast_clk,
  input  wire logic        strobe_read_shifted_clk,
  input  wire logic        strobe_write_shifted_clk,
  input  wire logic        capture_polarity_sel,
  // core side
  input  wire logic        core_out_first,
  input  wire logic        core_out_second,
  input  wire logic        core_tristate_ctl,
  input  wire logic        local_set_reset,
  output logic             bypass_comb_in,
  output logic             bypass_clock_in,
  output logic             rise_capture_out,
  output logic             fall_or_sdr_capture_out,
  output logic             gear_lane_b_out
);
  localparam int NS = 6;  // synchronised pins
  localparam int TAPS = ioc_pkg::DYN_TAPS;
  // strobe, dynamic delay and gearbox presence by placement
  localparam bit IS_RIGHT = (EDGE == ioc_pkg::EDGE_RIGHT);
  localparam bit IS_BOT   = (EDGE == ioc_pkg::EDGE_BOTTOM);
  localparam bit HAS_GEAR = (EDGE == ioc_pkg::EDGE_TOP) && (CELL_IDX == 2'h0);

  logic [NS-1:0]  sync1_q;  // first synchroniser stage
  logic [NS-1:0]  sync2_q;  // second synchroniser stage
  logic [NS-1:0]  prev_q;   // previous value for edges
  logic [ioc_pkg::CTRL_W-1:0] ctrl_q;   // control register
  logic [4:0]     delay_q;  // dynamic delay code
  logic [FIX_CYC-1:0] fix_q;  // fixed delay line
  logic [TAPS-1:0] dyn_q;   // dynamic delay line
  logic [4:0]     dyn_delay_code;
  logic           din;      // synchronised pad input
  logic           dly_in;   // input after delay choice
  logic           out_q;    // output data register
  logic           second_q; // held second half
  logic           tri_q;    // tristate register
  logic           fifo_ready;
  logic           gear_a;
  logic           gear_b;
  logic           gear_busy;
  logic           lsr;
  // decoded control bits
  logic c_byp, c_fix, c_dyn, c_ddr, c_stb, c_init, c_comp, c_gear, c_run;
  ioc_pkg::ioc_gmode_t gmode;
  // edge events
  logic sys_rise, sys_fall, fast_rise;
  logic srd_rise, srd_fall, swr_rise, swr_fall;
  logic cap_pos, cap_neg, lau_pos, lau_neg, pol;
  // bus decode
  logic acc, hit_ctrl, hit_dly, hit_stat, hit_gear, mapped, wr_fire;
  logic [31:0] rd_word;

  ioc_if #(.W(8)) gear_if ();

  // rising edge of one synchronised pin
  function automatic logic rose(input logic [NS-1:0] c,
                                input logic [NS-1:0] p, input int i);
    return c[i] & ~p[i];
  endfunction

  // falling edge of one synchronised pin
  function automatic logic fell(input logic [NS-1:0] c,
                                input logic [NS-1:0] p, input int i);
    return ~c[i] & p[i];
  endfunction

  // two flip-flops for every pin input, then edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else begin
      sync1_q <= {capture_polarity_sel, strobe_write_shifted_clk,
                  strobe_read_shifted_clk, edge_fast_clk,
                  core_sys_clk, pad_data_in};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign din       = sync2_q[0];
  assign sys_rise  = rose(sync2_q, prev_q, 1);
  assign sys_fall  = fell(sync2_q, prev_q, 1);
  assign fast_rise = rose(sync2_q, prev_q, 2);
  assign srd_rise  = rose(sync2_q, prev_q, 3);
  assign srd_fall  = fell(sync2_q, prev_q, 3);
  assign swr_rise  = rose(sync2_q, prev_q, 4);
  assign swr_fall  = fell(sync2_q, prev_q, 4);

  // control fields
  assign c_byp  = ctrl_q[ioc_pkg::CB_BYPASS];
  assign c_fix  = ctrl_q[ioc_pkg::CB_FIXDLY];
  assign c_dyn  = ctrl_q[ioc_pkg::CB_DYNDLY] & IS_BOT;
  assign c_ddr  = ctrl_q[ioc_pkg::CB_DDR];
  assign c_stb  = ctrl_q[ioc_pkg::CB_STROBE] & IS_RIGHT;
  assign c_init = ctrl_q[ioc_pkg::CB_INIT];
  assign c_comp = ctrl_q[ioc_pkg::CB_COMP];
  assign c_gear = ctrl_q[ioc_pkg::CB_GEAR] & HAS_GEAR;
  assign c_run  = ctrl_q[ioc_pkg::CB_RUN];
  assign gmode  = ioc_pkg::ioc_gmode_t'(ctrl_q[ioc_pkg::CB_GMODE +: 2]);
  assign lsr    = local_set_reset;
  assign dyn_delay_code = delay_q;

  // capture and launch edges, strobe clocks on right edge
  assign pol     = IS_RIGHT & sync2_q[5];
  assign cap_pos = pol ? (c_stb ? srd_fall : sys_fall)
                       : (c_stb ? srd_rise : sys_rise);
  assign cap_neg = pol ? (c_stb ? srd_rise : sys_rise)
                       : (c_stb ? srd_fall : sys_fall);
  assign lau_pos = c_stb ? swr_rise : sys_rise;
  assign lau_neg = c_stb ? swr_fall : sys_fall;

  // apb decode
  assign acc      = psel & penable;
  assign hit_ctrl = (paddr == ioc_pkg::OFS_CTRL);
  assign hit_dly  = (paddr == ioc_pkg::OFS_DELAY);
  assign hit_stat = (paddr == ioc_pkg::OFS_STATUS);
  assign hit_gear = (paddr == ioc_pkg::OFS_GEAR);
  assign mapped   = hit_ctrl | hit_dly | hit_stat | hit_gear;
  assign wr_fire  = acc & pready & pwrite & mapped;

  // read data selection
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_ctrl) rd_word[ioc_pkg::CTRL_W-1:0] = ctrl_q;
    else if (hit_dly) rd_word[4:0] = delay_q;
    else if (hit_stat)
      rd_word[7:0] = {gear_busy, ~fifo_ready, tri_q, out_q,
                      fall_or_sdr_capture_out, rise_capture_out,
                      dly_in, din};
  end

  // apb answer one cycle into access, gear writes wait for room
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (pready) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (acc && !(pwrite && hit_gear && !fifo_ready)) begin
      pready  <= 1'b1;
      pslverr <= ~mapped;
      prdata  <= pwrite ? 32'h0000_0000 : rd_word;
    end
  end

  // control register, mode fields frozen while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_q <= ioc_pkg::CTRL_RST;
    else if (wr_fire && hit_ctrl) begin
      ctrl_q[ioc_pkg::CB_RUN] <= pwdata[ioc_pkg::CB_RUN];
      if (!c_run)
        ctrl_q[ioc_pkg::CB_RUN-1:0] <= pwdata[ioc_pkg::CB_RUN-1:0];
    end
  end

  // dynamic delay code may change at any time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) delay_q <= ioc_pkg::DELAY_RST;
    else if (wr_fire && hit_dly) delay_q <= pwdata[4:0];
  end

  // delay lines shift every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fix_q <= '0;
      dyn_q <= '0;
    end else begin
      fix_q <= {fix_q[FIX_CYC-2:0], din};
      dyn_q <= {dyn_q[TAPS-2:0], din};
    end
  end

  // delay choice ahead of capture registers
  always_comb begin
    if (c_dyn) dly_in = dyn_q[dyn_delay_code];
    else if (c_fix) dly_in = fix_q[FIX_CYC-1];
    else dly_in = din;
  end

  // raw pad value straight to core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bypass_comb_in  <= 1'b0;
      bypass_clock_in <= 1'b0;
    end else begin
      bypass_comb_in  <= din;
      bypass_clock_in <= din;
    end
  end

  // input capture registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_capture_out        <= 1'b0;
      fall_or_sdr_capture_out <= 1'b0;
    end else if (lsr) begin
      rise_capture_out        <= c_init;
      fall_or_sdr_capture_out <= c_init;
    end else if (!c_byp) begin
      if (c_ddr) begin
        if (cap_pos) rise_capture_out <= dly_in;
        if (cap_neg) fall_or_sdr_capture_out <= dly_in;
      end else if (cap_pos) begin
        fall_or_sdr_capture_out <= dly_in;
      end
    end
  end

  // output register, second half only in double rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q    <= 1'b0;
      second_q <= 1'b0;
    end else if (lsr) begin
      out_q    <= c_init;
      second_q <= c_init;
    end else if (lau_pos) begin
      out_q    <= core_out_first;
      second_q <= core_out_second;
    end else if (lau_neg && c_ddr) begin
      out_q <= second_q;
    end
  end

  // tristate register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tri_q <= 1'b1;
    else if (lsr) tri_q <= c_init;
    else if (lau_pos) tri_q <= core_tristate_ctl;
  end

  // pad drivers, serializer lane replaces output register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_data_out     <= 1'b0;
      pad_pair_out     <= 1'b0;
      pad_data_oe      <= 1'b0;
      pad_tristate_ctl <= 1'b1;
      gear_lane_b_out  <= 1'b0;
    end else begin
      pad_data_out     <= c_gear ? gear_a : out_q;
      pad_pair_out     <= c_comp & ~(c_gear ? gear_a : out_q);
      pad_tristate_ctl <= tri_q;
      pad_data_oe      <= ~tri_q;
      gear_lane_b_out  <= c_gear & gear_b;
    end
  end

  // buffer takes parallel words written by software
  ioc_fifo2 #(.W(8), .DEPTH(2)) u_fifo (
    .clk      (pclk),
    .rst_n    (presetn),
    .in_valid (wr_fire & hit_gear),
    .in_data  (pwdata[7:0]),
    .in_ready (fifo_ready),
    .out      (gear_if.src)
  );

  // serializer, enabled only in the lead cell of top groups
  ioc_gearbox #(.W(8)) u_gear (
    .clk     (pclk),
    .rst_n   (presetn),
    .slow_en (sys_rise),
    .fast_en (fast_rise),
    .enable  (c_gear),
    .lsr     (lsr),
    .mode    (gmode),
    .in      (gear_if.snk),
    .ser_a   (gear_a),
    .ser_b   (gear_b),
    .busy    (gear_busy)
  );

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_sdr_launch;
    lau_pos && !lsr && !c_ddr && !c_gear;
  endsequence
  sequence s_quiet;
    !lsr && !lau_pos && !lau_neg;
  endsequence

  property p_bypass;
    ##3 bypass_comb_in == $past(pad_data_in, 3);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass output does not follow pad");

  property p_fixdly;
    (c_fix && !c_dyn) |-> dly_in == $past(din, FIX_CYC);
  endproperty
  a_fixdly: assert property (p_fixdly)
    else $error("fixed delay length wrong");

  property p_dyn0;
    (c_dyn && dyn_delay_code == 5'h00) |-> dly_in == $past(din);
  endproperty
  a_dyn0: assert property (p_dyn0)
    else $error("dynamic delay tap wrong");

  property p_sdr;
    (cap_pos && !c_ddr && !c_byp && !lsr)
      |=> fall_or_sdr_capture_out == $past(dly_in);
  endproperty
  a_sdr: assert property (p_sdr)
    else $error("single rate capture missed");

  property p_ddr_fall;
    (cap_neg && c_ddr && !c_byp && !lsr)
      |=> fall_or_sdr_capture_out == $past(dly_in);
  endproperty
  a_ddr_fall: assert property (p_ddr_fall)
    else $error("falling sample missed");

  property p_ddr_rise;
    (cap_pos && c_ddr && !c_byp && !lsr)
      |=> rise_capture_out == $past(dly_in);
  endproperty
  a_ddr_rise: assert property (p_ddr_rise)
    else $error("rising sample missed");

  property p_launch;
    s_sdr_launch ##1 s_quiet |=> pad_data_out == $past(core_out_first, 2);
  endproperty
  a_launch: assert property (p_launch)
    else $error("output register not at pad");

  property p_tri;
    (lau_pos && !lsr) ##1 s_quiet
      |=> pad_data_oe == !$past(core_tristate_ctl, 2);
  endproperty
  a_tri: assert property (p_tri)
    else $error("tristate path wrong");

  property p_lsr;
    lsr |=> (rise_capture_out == $past(c_init))
            && (out_q == $past(c_init)) && (tri_q == $past(c_init));
  endproperty
  a_lsr: assert property (p_lsr)
    else $error("local reset did not force init");

  property p_pair;
    $past(c_comp) |-> pad_pair_out == !pad_data_out;
  endproperty
  a_pair: assert property (p_pair)
    else $error("pair output not inverted");

  property p_static;
    (c_run && wr_fire && hit_ctrl)
      |=> ctrl_q[ioc_pkg::CB_RUN-1:0] == $past(ctrl_q[ioc_pkg::CB_RUN-1:0]);
  endproperty
  a_static: assert property (p_static)
    else $error("mode changed while running");
endmodule

// >>> verif/ioc_pad_model.sv
// pad-side model: pad input level and the slow and fast pin clocks
`timescale 1ns/1ns
module ioc_pad_model (
  // clock
  input  wire logic pclk,
  // pins toward the cell
  output logic      pad_data_in,
  output logic      core_sys_clk,
  output logic      edge_fast_clk
);
  // pins idle low, clocks stand still until a task moves them
  initial begin
    pad_data_in   = 1'b0;
    core_sys_clk  = 1'b0;
    edge_fast_clk = 1'b0;
  end
  // new pad level, then room for the synchroniser
  task automatic set_pad(input logic v);
    @(posedge pclk);
    pad_data_in <= v;
    repeat (4) @(posedge pclk);
  endtask
  // slow clock level, held long enough to be seen as an edge
  task automatic sys_set(input logic v);
    @(posedge pclk);
    core_sys_clk <= v;
    repeat (8) @(posedge pclk);
  endtask
  // one full fast clock period
  task automatic fast_pulse();
    @(posedge pclk);
    edge_fast_clk <= 1'b1;
    repeat (4) @(posedge pclk);
    edge_fast_clk <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
endmodule

// >>> verif/io_cell_sdr_ddr_registers_bench.sv
// testbench: apb master, core-side driver and checks of the io cell
`timescale 1ns/1ns
module io_cell_sdr_ddr_registers_bench;
  logic        pclk = 1'b0;  // apb clock
  logic        presetn = 1'b0;  // async reset
  logic [7:0]  paddr = 8'h00;  // byte address
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, r;  // data words
  logic        pready, pslverr, e;  // answer
  logic        pad_data_in, pad_data_out, pad_data_oe, pad_pair_out;
  logic        pad_tristate_ctl, core_sys_clk, edge_fast_clk;
  logic        core_out_first = 1'b0, core_out_second = 1'b0;
  logic        core_tristate_ctl = 1'b1, local_set_reset = 1'b0;
  logic        bypass_comb_in, bypass_clock_in, rise_capture_out;
  logic        fall_or_sdr_capture_out, gear_lane_b_out;
  logic        srd_clk = 1'b0, swr_clk = 1'b0, cap_pol = 1'b0;  // strobe pins
  logic        r_rise, r_fall, r_out;  // right cell outputs
  int          n_errors = 0, comparisons = 0;  // counters
  // 100 ns clock
  always #50 pclk = ~pclk;
  ioc_top #(.EDGE(ioc_pkg::EDGE_TOP)) dut_u (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pad_data_in(pad_data_in),
    .pad_data_out(pad_data_out), .pad_data_oe(pad_data_oe),
    .pad_pair_out(pad_pair_out), .pad_tristate_ctl(pad_tristate_ctl),
    .core_sys_clk(core_sys_clk), .edge_fast_clk(edge_fast_clk),
    .strobe_read_shifted_clk(srd_clk), .strobe_write_shifted_clk(swr_clk),
    .capture_polarity_sel(cap_pol), .core_out_first(core_out_first),
    .core_out_second(core_out_second),
    .core_tristate_ctl(core_tristate_ctl),
    .local_set_reset(local_set_reset), .bypass_comb_in(bypass_comb_in),
    .bypass_clock_in(bypass_clock_in),
    .rise_capture_out(rise_capture_out),
    .fall_or_sdr_capture_out(fall_or_sdr_capture_out),
    .gear_lane_b_out(gear_lane_b_out));
  ioc_pad_model pm_u (.pclk(pclk), .pad_data_in(pad_data_in),
    .core_sys_clk(core_sys_clk), .edge_fast_clk(edge_fast_clk));
  // right-edge cell on the same bus and pins, for the strobe paths
  ioc_top #(.EDGE(ioc_pkg::EDGE_RIGHT)) dut_r (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .pad_data_in(pad_data_in), .pad_data_out(r_out), .pad_data_oe(),
    .pad_pair_out(), .pad_tristate_ctl(), .core_sys_clk(core_sys_clk),
    .edge_fast_clk(edge_fast_clk), .strobe_read_shifted_clk(srd_clk),
    .strobe_write_shifted_clk(swr_clk), .capture_polarity_sel(cap_pol),
    .core_out_first(core_out_first), .core_out_second(core_out_second),
    .core_tristate_ctl(core_tristate_ctl), .local_set_reset(local_set_reset),
    .bypass_comb_in(), .bypass_clock_in(), .rise_capture_out(r_rise),
    .fall_or_sdr_capture_out(r_fall), .gear_lane_b_out());
  // verdict and end of run
  task automatic wrap_up();
    if (n_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one comparison
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, waits for pready, watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // reset values and unmapped access
  task automatic t_reset();
    apb(1'b0, ioc_pkg::OFS_CTRL, 32'h0);
    check(r, 32'h0);
    apb(1'b0, ioc_pkg::OFS_DELAY, 32'h0);
    check(r, 32'h0);
    check(pad_tristate_ctl, 1'b1);
    check(pad_data_oe, 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    check(r, 32'h0);
    check(e, 1'b1);
  endtask
  // raw pad value on both bypass outputs
  task automatic t_bypass();
    pm_u.set_pad(1'b1);
    check(bypass_comb_in, 1'b1);
    check(bypass_clock_in, 1'b1);
    pm_u.set_pad(1'b0);
    check({bypass_comb_in, bypass_clock_in}, 2'b00);
  endtask
  // single rate, then double rate capture
  task automatic t_capture();
    apb(1'b1, ioc_pkg::OFS_CTRL, 32'h0);
    pm_u.set_pad(1'b1);
    pm_u.sys_set(1'b1);
    pm_u.sys_set(1'b0);
    check(fall_or_sdr_capture_out, 1'b1);
    check(rise_capture_out, 1'b0);
    apb(1'b1, ioc_pkg::OFS_CTRL, 32'h8);
    pm_u.sys_set(1'b1);
    pm_u.set_pad(1'b0);
    pm_u.sys_set(1'b0);
    check(rise_capture_out, 1'b1);
    check(fall_or_sdr_capture_out, 1'b0);
  endtask
  // output, pair and tristate paths, then local set/reset
  task automatic t_out();
    apb(1'b1, ioc_pkg::OFS_CTRL, 32'h40);
    core_out_first <= 1'b1;
    core_tristate_ctl <= 1'b0;
    pm_u.sys_set(1'b1);
    check(pad_data_out, 1'b1);
    check(pad_pair_out, 1'b0);
    check({pad_tristate_ctl, pad_data_oe}, 2'b01);
    pm_u.sys_set(1'b0);
    apb(1'b1, ioc_pkg::OFS_CTRL, 32'h48);
    core_out_first <= 1'b0;
    core_out_second <= 1'b1;
    pm_u.sys_set(1'b1);
    check({pad_data_out, pad_pair_out}, 2'b01);
    pm_u.sys_set(1'b0);
    check(pad_data_out, 1'b1);
    apb(1'b1, ioc_pkg::OFS_CTRL, 32'h20);
    local_set_reset <= 1'b1;
    @(posedge pclk);
    local_set_reset <= 1'b0;
    repeat (3) @(posedge pclk);
    check(fall_or_sdr_capture_out, 1'b1);
    check({pad_tristate_ctl, pad_data_out}, 2'b11);
  endtask
  // serializer modes, run lock, buffer fill and drain
  task automatic t_gear();
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, ioc_pkg::OFS_CTRL, 32'h80 | (m << 8));
      apb(1'b0, ioc_pkg::OFS_CTRL, 32'h0);
      check(r, 32'h80 | (m << 8));
    end
    apb(1'b1, ioc_pkg::OFS_CTRL, 32'h580);
    apb(1'b1, ioc_pkg::OFS_CTRL, 32'h0);
    apb(1'b0, ioc_pkg::OFS_CTRL, 32'h0);
    check(r[9:0], 10'h180);
    apb(1'b1, ioc_pkg::OFS_GEAR, 32'hA5);
    apb(1'b1, ioc_pkg::OFS_GEAR, 32'h3C);
    apb(1'b0, ioc_pkg::OFS_STATUS, 32'h0);
    check(r[6], 1'b1);
    pm_u.sys_set(1'b1);
    pm_u.sys_set(1'b0);
    for (int i = 0; i < 8; i++) begin
      pm_u.fast_pulse();
      check(pad_data_out, (32'hA5 >> i) & 32'h1);
    end
    pm_u.fast_pulse();
    apb(1'b0, ioc_pkg::OFS_STATUS, 32'h0);
    check(r[7:6], 2'b00);
    apb(1'b1, ioc_pkg::OFS_CTRL, 32'h280);
    pm_u.sys_set(1'b1);
    pm_u.sys_set(1'b0);
    // word 3C: lane b bits 7:4, lane a bits 3:0, pairs {b,a} packed
    for (int i = 0; i < 4; i++) begin
      pm_u.fast_pulse();
      check({gear_lane_b_out, pad_data_out}, (32'h5A >> 2 * i) & 32'h3);
    end
  endtask
  // pad level, then read strobe level, then settle
  task automatic stb(input logic p, input logic s);
    pm_u.set_pad(p);
    srd_clk <= s;
    repeat (5) @(posedge pclk);
  endtask
  // strobe pins drive the right cell, the top cell ignores them
  task automatic t_strobe();
    apb(1'b1, ioc_pkg::OFS_CTRL, 32'h18);
    core_out_first <= 1'b1;
    swr_clk <= 1'b1;
    stb(1'b0, 1'b1);
    stb(1'b1, 1'b0);
    check({r_rise, r_fall, r_out}, 3'b011);
    cap_pol <= 1'b1;
    stb(1'b0, 1'b1);
    stb(1'b1, 1'b0);
    check({r_rise, r_fall}, 2'b10);
    check({rise_capture_out, fall_or_sdr_capture_out}, 2'b10);
  endtask
  // watchdog
  initial begin
    #(20000 * 100);
    n_errors++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_bypass();
    t_capture();
    t_out();
    t_gear();
    t_strobe();
    wrap_up();
  end
endmodule
